// ---- keyscan_defines.svh ----
// Register offsets, field positions, reset values and timing counts for the key configuration bank
`ifndef KEYSCAN_DEFINES_SVH
`define KEYSCAN_DEFINES_SVH

`define CFG_OFFSET         8'h01
`define DEB_OFFSET         8'h02
`define CFG_SLEEP_BIT      7
`define CFG_INTMODE_BIT    5
`define CFG_RELEASE_BIT    3
`define CFG_AUTOWAKE_BIT   1
`define CFG_TODIS_BIT      0
`define CFG_RESET          8'h00
`define CFG_WRITE_MASK     8'hab
`define DEB_RESET          8'hff
`define DEB_STEP_MS        2
`define CLK_HZ             100000000
`define DEB_STEP_CYCLES    (`DEB_STEP_MS * (`CLK_HZ / 1000))

`endif

// ---- keyscan_pkg.sv ----
// Types used by the debounce timer of the key configuration bank
package keyscan_pkg;
    typedef enum logic [2:0] {
        DB_IDLE  = 3'b001,
        DB_COUNT = 3'b010,
        DB_DONE  = 3'b100
    } db_state_type;
endpackage

// ---- debounce_if.sv ----
// Signals between the configuration bank and the debounce timer
`timescale 1ns/1ps
interface debounce_if;
    logic [3:0] press_code;
    logic [3:0] release_code;
    logic       key_level;
    logic       stable_level;
    logic       event_pulse;
    modport bank  (output press_code, output release_code, output key_level,
                   input stable_level, input event_pulse);
    modport timer (input press_code, input release_code, input key_level,
                   output stable_level, output event_pulse);
endinterface

// ---- keyscan_debounce.sv ----
// Debounce timer: reports a key change once it held for the programmed time
`timescale 1ns/1ps
`include "keyscan_defines.svh"
module keyscan_debounce (
    input  wire logic clk,   // System clock
    input  wire logic nrst,  // Asynchronous reset, active low
    debounce_if.timer db     // Codes in, debounced level out
);
    localparam int unsigned STEP = `DEB_STEP_CYCLES;
    logic [31:0]                 cnt_r, cnt_nxt;
    logic                        stable_r, stable_nxt;
    logic                        ev_r, ev_nxt;
    keyscan_pkg::db_state_type   st_r, st_nxt;

    // Cycles needed for a code: 2 ms times (code plus one)
    function automatic logic [31:0] span(input logic [3:0] code);
        span = STEP * ({28'h0, code} + 32'h1);
    endfunction

    // Count while the input differs from the stable level
    always_comb begin
        cnt_nxt    = cnt_r;
        stable_nxt = stable_r;
        ev_nxt     = 1'b0;
        st_nxt     = st_r;
        case (st_r)
            keyscan_pkg::DB_IDLE: begin
                cnt_nxt = 32'h0;
                if (db.key_level != stable_r) begin
                    st_nxt = keyscan_pkg::DB_COUNT;
                end
            end
            keyscan_pkg::DB_COUNT: begin
                if (db.key_level == stable_r) begin
                    st_nxt = keyscan_pkg::DB_IDLE; // Bounce restarts the wait
                end else if (cnt_r + 32'h2 >= span(stable_r ? db.release_code : db.press_code)) begin
                    st_nxt = keyscan_pkg::DB_DONE;
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            keyscan_pkg::DB_DONE: begin
                // A bounce on the last count edge must not yield an event with no change
                if (db.key_level != stable_r) begin
                    stable_nxt = db.key_level; // Report only after full hold
                    ev_nxt     = 1'b1;
                end
                st_nxt     = keyscan_pkg::DB_IDLE;
            end
            default: st_nxt = keyscan_pkg::DB_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r    <= 32'h0;
            stable_r <= 1'b0;
            ev_r     <= 1'b0;
            st_r     <= keyscan_pkg::DB_IDLE;
        end else begin
            cnt_r    <= cnt_nxt;
            stable_r <= stable_nxt;
            ev_r     <= ev_nxt;
            st_r     <= st_nxt;
        end
    end

    assign db.stable_level = stable_r;
    assign db.event_pulse  = ev_r;

    // An event always comes with a changed level
    a_event_level_change: assert property (@(posedge clk) disable iff (!nrst)
        ev_r |-> $changed(stable_r)) else $error("Debounce event without level change");
    // No event while the input had just bounced back
    a_event_needs_hold: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == keyscan_pkg::DB_COUNT && db.key_level == stable_r) |=> !ev_r)
        else $error("Debounce event after bounce");
    c_release_event: cover property (@(posedge clk) disable iff (!nrst) ev_r && !stable_r);
endmodule // keyscan_debounce

// ---- keyscan_config_debounce_regs.sv ----
// Configuration and debounce register bank of the key-switch controller
//
// Operation
// - PWM enable forces operating mode, blocks sleep
// - Otherwise host, autosleep, autowake change sleep
// - Reads return live sleep state
// - Mode 0: interrupt clears when FIFO empty
// - Timeout-disable bit 0 turns bus timeout off
// - Release queuing bit 3, autowake bit 1
// - Debounce nibbles: 2 ms times code plus one
`timescale 1ns/1ps
`include "keyscan_defines.svh"
module keyscan_config_debounce_regs (
    input  wire logic       clk,             // System clock, 100 MHz
    input  wire logic       nrst,            // Asynchronous reset, active low
    input  wire logic       reg_wr,          // Register write strobe
    input  wire logic       reg_rd,          // Register read strobe
    input  wire logic [7:0] reg_addr,        // Register offset
    input  wire logic [7:0] reg_wdata,       // Write data
    output logic      [7:0] reg_rdata,       // Read data, registered
    input  wire logic       pwm_cc_enable,   // Constant-current PWM enabled
    input  wire logic       autosleep_req,   // Autosleep timeout pulse
    input  wire logic       wake_keypress,   // Keypress seen during sleep
    input  wire logic       fifo_empty,      // Key event FIFO empty
    input  wire logic       fifo_read,       // Host read of the key FIFO
    input  wire logic       key_event,       // New key event queued
    input  wire logic       key_pin,         // Raw key level, pin domain
    output logic            key_stable,      // Debounced key level
    output logic            key_changed,     // One-cycle debounced change
    output logic            key_int,         // Key interrupt, active high
    output logic            operating,       // Chip in key-switch operating mode
    output logic            release_enable,  // Queue key releases
    output logic            autowake_enable, // Keypress wakeup enabled
    output logic            bus_timeout_en   // Serial bus timeout enabled
);
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] deb_r, deb_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       int_r, int_nxt;
    logic [2:0] sync_r;
    logic       key_r, key_nxt;
    logic       sleep_bit;
    logic [2:0] sync_nxt;
    logic       cfg_wr;
    logic       deb_wr;
    logic       cfg_rd;
    debounce_if dbi ();

    // Pin synchroniser: level counts when stages two and three agree
    always_comb begin
        sync_nxt = {sync_r[1:0], key_pin};
        key_nxt  = (sync_r[2] == sync_r[1]) ? sync_r[2] : key_r;
    end

    // Synchroniser registers; the pin may move at any time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_r <= 3'h0;
            key_r  <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            key_r  <= key_nxt;
        end
    end

    // Address match shared by the strobe decodes and the checks
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
        addr_hit = (addr == offset);
    endfunction

    // Strobe decodes per register
    assign cfg_wr = reg_wr & addr_hit(reg_addr, `CFG_OFFSET);
    assign deb_wr = reg_wr & addr_hit(reg_addr, `DEB_OFFSET);
    assign cfg_rd = reg_rd & addr_hit(reg_addr, `CFG_OFFSET);

    // Register next values and sleep control
    always_comb begin
        cfg_nxt   = cfg_r;
        deb_nxt   = deb_r;
        rdata_nxt = rdata_r;
        int_nxt   = int_r;
        if (cfg_wr) begin
            cfg_nxt = reg_wdata & `CFG_WRITE_MASK; // Reserved bits kept zero
        end
        if (deb_wr) begin
            deb_nxt = reg_wdata;
        end
        // Under PWM the stored bit keeps host writes; only operating is forced
        if (!pwm_cc_enable) begin
            if (autosleep_req) begin
                cfg_nxt[`CFG_SLEEP_BIT] = 1'b0;
            end
            if (wake_keypress && cfg_r[`CFG_AUTOWAKE_BIT]) begin
                cfg_nxt[`CFG_SLEEP_BIT] = 1'b1; // Autowake wins over sleep
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                `CFG_OFFSET: rdata_nxt = {sleep_bit, cfg_r[6:0]}; // Live state
                `DEB_OFFSET: rdata_nxt = deb_r;
                default:     rdata_nxt = 8'h00;
            endcase
        end
        // Interrupt: set wins over clear
        if (key_event) begin
            int_nxt = 1'b1;
        end else if (cfg_r[`CFG_INTMODE_BIT] ? fifo_read : fifo_empty) begin
            int_nxt = 1'b0;
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r   <= `CFG_RESET; // Starts in shutdown
            deb_r   <= `DEB_RESET; // 32 ms both
            rdata_r <= 8'h00;
            int_r   <= 1'b0;
        end else begin
            cfg_r   <= cfg_nxt;
            deb_r   <= deb_nxt;
            rdata_r <= rdata_nxt;
            int_r   <= int_nxt;
        end
    end

    assign sleep_bit       = pwm_cc_enable | cfg_r[`CFG_SLEEP_BIT];
    assign operating       = sleep_bit;
    assign reg_rdata       = rdata_r;
    assign key_int         = int_r;
    assign release_enable  = cfg_r[`CFG_RELEASE_BIT];
    assign autowake_enable = cfg_r[`CFG_AUTOWAKE_BIT];
    assign bus_timeout_en  = ~cfg_r[`CFG_TODIS_BIT];

    // Debounce timer hookup
    assign dbi.press_code   = deb_r[3:0];
    assign dbi.release_code = deb_r[7:4];
    assign dbi.key_level    = key_r;
    assign key_stable       = dbi.stable_level;
    assign key_changed      = dbi.event_pulse;

    keyscan_debounce u_deb (
        .clk  (clk),
        .nrst (nrst),
        .db   (dbi.timer)
    );

    // Sleep control, readback, interrupt and register checks
    a_pwm_keeps_on: assert property (@(posedge clk) disable iff (!nrst)
        pwm_cc_enable |-> operating) else $error("Sleep while PWM enabled");
    a_autosleep_clears: assert property (@(posedge clk) disable iff (!nrst)
        (autosleep_req && !wake_keypress && !pwm_cc_enable && !(reg_wr && reg_addr == `CFG_OFFSET))
        |=> !cfg_r[`CFG_SLEEP_BIT]) else $error("Autosleep ignored");
    a_read_live_sleep: assert property (@(posedge clk) disable iff (!nrst)
        (reg_rd && reg_addr == `CFG_OFFSET) |=> rdata_r[`CFG_SLEEP_BIT] == $past(operating))
        else $error("Sleep readback wrong");
    a_int_mode0_hold: assert property (@(posedge clk) disable iff (!nrst)
        (int_r && !cfg_r[`CFG_INTMODE_BIT] && !fifo_empty) |=> int_r)
        else $error("Interrupt cleared with FIFO not empty");
    a_int_mode1_clear: assert property (@(posedge clk) disable iff (!nrst)
        (cfg_r[`CFG_INTMODE_BIT] && fifo_read && !key_event) |=> !int_r)
        else $error("Interrupt not cleared on read");
    a_timeout_ctrl: assert property (@(posedge clk) disable iff (!nrst)
        cfg_wr |=> bus_timeout_en == !$past(reg_wdata[`CFG_TODIS_BIT]))
        else $error("Timeout control wrong");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        (cfg_r[6] | cfg_r[4] | cfg_r[2]) == 1'b0) else $error("Reserved bit set");
    a_debounce_write: assert property (@(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == `DEB_OFFSET) |=> deb_r == $past(reg_wdata))
        else $error("Debounce write lost");

    // Autowake raises the sleep bit when allowed
    a_wake_sets: assert property (@(posedge clk) disable iff (!nrst)
        (wake_keypress && cfg_r[`CFG_AUTOWAKE_BIT] && !pwm_cc_enable) |=> cfg_r[`CFG_SLEEP_BIT])
        else $error("Autowake ignored");

    // Host write moves the sleep bit when nothing else claims it
    a_host_sleep_write: assert property (@(posedge clk) disable iff (!nrst)
        (cfg_wr && !autosleep_req && !wake_keypress && !pwm_cc_enable)
        |=> cfg_r[`CFG_SLEEP_BIT] == $past(reg_wdata[`CFG_SLEEP_BIT]))
        else $error("Host sleep write lost");

    // PWM freezes the stored sleep bit against autosleep and autowake
    a_pwm_blocks_sleep: assert property (@(posedge clk) disable iff (!nrst)
        (pwm_cc_enable && !cfg_wr) |=> $stable(cfg_r[`CFG_SLEEP_BIT]))
        else $error("Sleep bit moved under PWM");
    a_pwm_reads_on: assert property (@(posedge clk) disable iff (!nrst)
        (pwm_cc_enable && cfg_rd) |=> reg_rdata[`CFG_SLEEP_BIT])
        else $error("Sleep reported under PWM");

    // A queued key event raises the interrupt; mode 0 drops it on an empty FIFO
    a_int_set: assert property (@(posedge clk) disable iff (!nrst)
        key_event |=> key_int) else $error("Interrupt not raised");
    a_int_mode0_clear: assert property (@(posedge clk) disable iff (!nrst)
        (!cfg_r[`CFG_INTMODE_BIT] && fifo_empty && !key_event) |=> !key_int)
        else $error("Interrupt kept with FIFO empty");

    // Release queuing and autowake follow the host write
    a_cfg_flags: assert property (@(posedge clk) disable iff (!nrst)
        cfg_wr |=> (release_enable == $past(reg_wdata[`CFG_RELEASE_BIT]))
                && (autowake_enable == $past(reg_wdata[`CFG_AUTOWAKE_BIT])))
        else $error("Configuration flags wrong");

    // Read data stands until the next read; unmapped offsets read zero
    a_rdata_holds: assert property (@(posedge clk) disable iff (!nrst)
        !reg_rd |=> $stable(reg_rdata)) else $error("Read data changed without a read");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
        (reg_rd && !addr_hit(reg_addr, `CFG_OFFSET) && !addr_hit(reg_addr, `DEB_OFFSET))
        |=> reg_rdata == 8'h00)
        else $error("Unmapped read not zero");

    // Main scenarios; all but c_key_change are seen by the bench
    c_autowake: cover property (@(posedge clk) disable iff (!nrst) $rose(cfg_r[`CFG_SLEEP_BIT]));
    c_int_cleared: cover property (@(posedge clk) disable iff (!nrst) $fell(int_r));
    c_key_change: cover property (@(posedge clk) disable iff (!nrst) key_changed);
    c_pwm_override: cover property (@(posedge clk) disable iff (!nrst) pwm_cc_enable && !cfg_r[`CFG_SLEEP_BIT]);
endmodule // keyscan_config_debounce_regs

// ---- keyscan_host.sv ----
// Host model that issues register writes and reads to the key bank
`timescale 1ns/1ps
module keyscan_host (
    input  wire logic       clk,   // System clock
    output logic            wr,    // Write strobe
    output logic            rd,    // Read strobe
    output logic      [7:0] addr,  // Register offset
    output logic      [7:0] wdata, // Write data
    input  wire logic [7:0] rdata  // Read data
);
    logic [7:0] last; // Byte from the latest read
    // Idle bus at time zero
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // One write strobe; reserved configuration bits go out as zero
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= (a == 8'h01) ? (d & 8'hab) : d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    // One read strobe; data is taken once the registered answer settles
    task automatic read(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 last = rdata;
    endtask
endmodule // keyscan_host

// ---- tb_keyscan_config_debounce_regs.sv ----
// Self-checking testbench for the key configuration and debounce bank
`timescale 1ns/1ps
module tb_keyscan_config_debounce_regs;
    logic       clk, nrst, wr, rd, pwm, empty, key;     // Bench drives
    logic [7:0] addr, wdata, rdata;                     // Register bus
    logic [3:0] pul;                                    // Sleep, wake, event, FIFO read
    logic       stab, chg, kint, oper, rel, awk, bto;   // Design outputs
    logic [7:0] cfg_m, deb_m;                           // Model bytes
    int         n_errors, n_checks, nchg;
    int         seed = 32'hff0020c5;
    keyscan_config_debounce_regs DUT (.clk(clk), .nrst(nrst), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .pwm_cc_enable(pwm),
        .autosleep_req(pul[0]), .wake_keypress(pul[1]), .fifo_empty(empty), .fifo_read(pul[3]),
        .key_event(pul[2]), .key_pin(key), .key_stable(stab), .key_changed(chg), .key_int(kint),
        .operating(oper), .release_enable(rel), .autowake_enable(awk), .bus_timeout_en(bto));
    keyscan_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Comparison with counting
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Configuration byte as the host sees it, PWM forcing operating mode
    function automatic logic [7:0] shown();
        return {cfg_m[7] | pwm, cfg_m[6:0]};
    endfunction
    task automatic wrm(input logic [7:0] a, input logic [7:0] d);
        host.write(a, d);
        if (a == 8'h01) cfg_m = d & 8'hab;
        else if (a == 8'h02) deb_m = d;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.read(a);
        check("reg_rdata", host.last, exp);
    endtask
    // Pulse: 0 autosleep, 1 wake, 2 key event, 3 FIFO read
    task automatic ev(input int k);
        if (k == 0 && !pwm) cfg_m[7] = 1'b0;
        if (k == 1 && !pwm && cfg_m[1]) cfg_m[7] = 1'b1;
        @(posedge clk);
        pul <= 4'h1 << k;
        @(posedge clk);
        pul <= 4'h0;
        #1;
        check("operating", {7'h0, oper}, {7'h0, pwm | cfg_m[7]});
    endtask
    // Watchdog
    initial begin
        #200us;
        n_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        {nrst, pwm, empty, key, pul} = '0;
        {n_errors, n_checks, nchg} = '0;
        cfg_m = 8'h00;
        deb_m = 8'hff;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1 check("bus_timeout_en", {7'h0, bto}, 8'h01);
        rdchk(8'h01, 8'h00);
        rdchk(8'h02, 8'hff);
        wrm(8'h01, 8'hff);
        rdchk(8'h01, shown());
        wrm(8'h01, 8'h8b);
        #1 check("flags", {4'h0, oper, rel, awk, bto}, 8'h0e);
        wrm(8'h05, 8'h77);
        rdchk(8'h05, 8'h00);
        wrm(8'h02, 8'($random(seed)));
        rdchk(8'h02, deb_m);
        rdchk(8'h01, shown());
        // Sleep control without PWM, then with PWM forcing
        ev(0);
        rdchk(8'h01, shown());
        ev(1);
        wrm(8'h01, 8'h89);
        ev(0);
        ev(1);
        @(posedge clk) pwm <= 1'b1;
        wrm(8'h01, 8'h09);
        rdchk(8'h01, shown());
        ev(0);
        @(posedge clk) pwm <= 1'b0;
        wrm(8'h01, 8'h81);
        ev(1);
        // Interrupt clear in both modes
        ev(2);
        check("key_int", {7'h0, kint}, 8'h01);
        @(posedge clk) empty <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("key_int", {7'h0, kint}, 8'h00);
        wrm(8'h01, 8'ha1);
        ev(2);
        repeat (2) @(posedge clk);
        #1 check("key_int", {7'h0, kint}, 8'h01);
        ev(3);
        check("key_int", {7'h0, kint}, 8'h00);
        @(posedge clk) empty <= 1'b0;
        // Bouncing key never holds for the debounce span
        repeat (400) begin
            @(posedge clk);
            key <= 1'($random(seed));
            #1 if (chg === 1'b1) nchg++;
        end
        check("key_changed", nchg[7:0], 8'h00);
        check("key_stable", {7'h0, stab}, 8'h00);
        close_out();
    end
endmodule // tb_keyscan_config_debounce_regs
